// ### rtl/flash_block_erase_protect.sv
// Purpose: flash controller that erases 1 KB blocks and enforces 2 KB unit protection
// Assumes: array read data is valid the cycle after arr_rd_en; one request at a time
// Notes: erase is carried out as 256 writes of all ones through the array write port

`timescale 1ns/1ps

module flash_block_erase_protect
    import flash_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // protection setting
    input wire logic [CFG_BITS-1:0] prot_cfg,
    // read channel (fetch, data, debugger)
    input wire logic rd_req,
    input wire rd_kind_type rd_kind,
    input wire logic [ADDR_BITS-1:0] rd_addr,
    output logic rd_valid,
    output logic rd_err,
    output logic [WORD_BITS-1:0] rd_data,
    // program and erase channel
    input wire logic prog_req,
    input wire logic [ADDR_BITS-1:0] prog_addr,
    input wire logic [WORD_BITS-1:0] prog_data,
    input wire logic erase_req,
    input wire logic [BLK_BITS-1:0] erase_block,
    output logic op_done,
    output logic op_err,
    // shared request ready
    output logic req_ready,
    // flash array side
    output logic arr_rd_en,
    output logic [ADDR_BITS-1:0] arr_rd_addr,
    input wire logic [WORD_BITS-1:0] arr_rd_data,
    output logic arr_wr_en,
    output logic [ADDR_BITS-1:0] arr_wr_addr,
    output logic [WORD_BITS-1:0] arr_wr_data
);
    typedef enum logic [2:0] {st_idle, st_write, st_rd_wait, st_rd_capture, st_erase, st_erase_end} state_type;

    state_type state_r;
    logic [CNT_BITS-1:0] cnt_r;
    logic [BLK_BITS-1:0] blk_r;
    logic rd_valid_r, rd_err_r, op_done_r, op_err_r, arr_rd_en_r, arr_wr_en_r;
    logic [WORD_BITS-1:0] rd_data_r, arr_wr_data_r;
    logic [ADDR_BITS-1:0] arr_rd_addr_r, arr_wr_addr_r;

    logic accept_erase, accept_prog, accept_rd;
    logic [ADDR_BITS-1:0] chk_addr;
    logic in_range, wr_ok, dread_ok, rd_ok;
    prot_type chk_mode;

    // erase outranks program, program outranks read
    assign req_ready = state_r == st_idle;
    assign accept_erase = req_ready && erase_req;
    assign accept_prog = req_ready && prog_req && !erase_req;
    assign accept_rd = req_ready && rd_req && !erase_req && !prog_req;
    assign chk_addr = erase_req ? {erase_block, CNT_RESET} : (prog_req ? prog_addr : rd_addr);
    assign rd_ok = in_range && (rd_kind == kind_fetch || dread_ok);

    prot_check u_prot (
        .prot_cfg(prot_cfg),
        .word_addr(chk_addr),
        .in_range(in_range),
        .wr_ok(wr_ok),
        .dread_ok(dread_ok),
        .unit_mode(chk_mode)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= st_idle;
            cnt_r <= CNT_RESET;
            blk_r <= '0;
            rd_valid_r <= 1'b0;
            rd_err_r <= 1'b0;
            rd_data_r <= DENIED_WORD;
            op_done_r <= 1'b0;
            op_err_r <= 1'b0;
            arr_rd_en_r <= 1'b0;
            arr_rd_addr_r <= '0;
            arr_wr_en_r <= 1'b0;
            arr_wr_addr_r <= '0;
            arr_wr_data_r <= DENIED_WORD;
        end else begin
            rd_valid_r <= 1'b0;
            rd_err_r <= 1'b0;
            op_done_r <= 1'b0;
            op_err_r <= 1'b0;
            arr_rd_en_r <= 1'b0;
            arr_wr_en_r <= 1'b0;
            unique case (state_r)
                st_idle: begin
                    if (accept_erase) begin
                        if (wr_ok) begin
                            state_r <= st_erase;
                            blk_r <= erase_block;
                            cnt_r <= CNT_RESET;
                        end else begin
                            op_err_r <= 1'b1;
                        end
                    end else if (accept_prog) begin
                        if (wr_ok) begin
                            arr_wr_en_r <= 1'b1;
                            arr_wr_addr_r <= prog_addr;
                            arr_wr_data_r <= prog_data;
                            state_r <= st_write;
                        end else begin
                            op_err_r <= 1'b1;
                        end
                    end else if (accept_rd) begin
                        if (rd_ok) begin
                            arr_rd_en_r <= 1'b1;
                            arr_rd_addr_r <= rd_addr;
                            state_r <= st_rd_wait;
                        end else begin
                            // nothing from the array reaches rd_data on a refusal
                            rd_err_r <= 1'b1;
                            rd_data_r <= DENIED_WORD;
                        end
                    end
                end
                st_write: begin
                    op_done_r <= 1'b1;
                    state_r <= st_idle;
                end
                st_rd_wait: begin
                    state_r <= st_rd_capture;
                end
                st_rd_capture: begin
                    rd_data_r <= arr_rd_data;
                    rd_valid_r <= 1'b1;
                    state_r <= st_idle;
                end
                st_erase: begin
                    // only words of the latched block are touched
                    arr_wr_en_r <= 1'b1;
                    arr_wr_addr_r <= {blk_r, cnt_r};
                    arr_wr_data_r <= ERASED_WORD;
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == LAST_CNT) begin
                        state_r <= st_erase_end;
                    end
                end
                st_erase_end: begin
                    op_done_r <= 1'b1;
                    state_r <= st_idle;
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    assign rd_valid = rd_valid_r;
    assign rd_err = rd_err_r;
    assign rd_data = rd_data_r;
    assign op_done = op_done_r;
    assign op_err = op_err_r;
    assign arr_rd_en = arr_rd_en_r;
    assign arr_rd_addr = arr_rd_addr_r;
    assign arr_wr_en = arr_wr_en_r;
    assign arr_wr_addr = arr_wr_addr_r;
    assign arr_wr_data = arr_wr_data_r;

    // erase that passes protection finishes after exactly one block of writes
    property p_erase_len;
        @(posedge mclk) disable iff (srst)
        accept_erase && wr_ok |-> ##258 op_done;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase did not end after 256 writes");

    property p_erase_block;
        @(posedge mclk) disable iff (srst)
        accept_erase && wr_ok |-> ##2 (arr_wr_en && arr_wr_addr[BLK_POS +: BLK_BITS] == $past(erase_block, 2));
    endproperty
    a_erase_block: assert property (p_erase_block) else $error("erase wrote outside its block");

    property p_erase_ones;
        @(posedge mclk) disable iff (srst)
        accept_erase && wr_ok |-> ##2 (arr_wr_en && arr_wr_data == ERASED_WORD) [*8];
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase wrote a word other than all ones");

    property p_unit_map;
        @(posedge mclk) disable iff (srst)
        accept_erase && erase_block < BLK_BITS'(NUM_BLOCKS)
            |-> wr_ok == (prot_cfg[{erase_block[BLK_BITS-1:1], 1'b0} +: MODE_BITS] == 2'(prot_open));
    endproperty
    a_unit_map: assert property (p_unit_map) else $error("block did not follow its pair setting");

    property p_ro_refuse;
        @(posedge mclk) disable iff (srst)
        (accept_prog || accept_erase) && chk_mode == prot_read_only |=> op_err && req_ready && !arr_wr_en;
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("write reached a read-only unit");

    property p_xo_refuse;
        @(posedge mclk) disable iff (srst)
        (accept_prog || accept_erase) && chk_mode == prot_exec_only |=> op_err && req_ready && !arr_wr_en;
    endproperty
    a_xo_refuse: assert property (p_xo_refuse) else $error("write reached an execute-only unit");

    property p_xo_data;
        @(posedge mclk) disable iff (srst)
        accept_rd && rd_kind != kind_fetch && chk_mode == prot_exec_only |=> rd_err && !arr_rd_en;
    endproperty
    a_xo_data: assert property (p_xo_data) else $error("data read of execute-only unit allowed");

    property p_denied_blank;
        @(posedge mclk) disable iff (srst)
        rd_err |-> rd_data == DENIED_WORD && !rd_valid;
    endproperty
    a_denied_blank: assert property (p_denied_blank) else $error("refused read returned data");

    property p_read_ok;
        @(posedge mclk) disable iff (srst)
        accept_rd && rd_ok |-> ##3 rd_valid && !rd_err && rd_data == $past(arr_rd_data);
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("permitted read not answered in three cycles");

    c_erase: cover property (@(posedge mclk) disable iff (srst) accept_erase && wr_ok ##258 op_done);
    c_prog_refused: cover property (@(posedge mclk) disable iff (srst) accept_prog && !wr_ok ##1 op_err);
    c_xo_fetch: cover property (@(posedge mclk) disable iff (srst)
        accept_rd && rd_kind == kind_fetch && chk_mode == prot_exec_only ##3 rd_valid);
    c_prog_ok: cover property (@(posedge mclk) disable iff (srst) accept_prog && wr_ok ##2 op_done);
endmodule : flash_block_erase_protect

// ### rtl/flash_pkg.sv
// Purpose: shared sizes, encodings and word constants for the flash block controller
// Assumes: word addressing, 32-bit words
// Notes: protection mode codes follow the enum order

package flash_pkg;
    localparam int WORD_BITS = 32;
    localparam int ARRAY_KB = 96;
    localparam int BLOCK_KB = 1;
    localparam int UNIT_KB = 2;
    localparam int BYTES_PER_WORD = 4;
    localparam int NUM_WORDS = ARRAY_KB * 1024 / BYTES_PER_WORD;
    localparam int WORDS_PER_BLOCK = BLOCK_KB * 1024 / BYTES_PER_WORD;
    localparam int NUM_BLOCKS = ARRAY_KB / BLOCK_KB;
    localparam int NUM_UNITS = ARRAY_KB / UNIT_KB;
    localparam int ADDR_BITS = 15;
    localparam int BLK_BITS = 7;
    localparam int UNIT_BITS = 6;
    localparam int CNT_BITS = 8;
    localparam int BLK_POS = 8;
    localparam int UNIT_POS = 9;
    localparam int MODE_BITS = 2;
    localparam int CFG_BITS = NUM_UNITS * MODE_BITS;
    localparam logic [ADDR_BITS-1:0] LAST_WORD = ADDR_BITS'(NUM_WORDS - 1);
    localparam logic [CNT_BITS-1:0] LAST_CNT = CNT_BITS'(WORDS_PER_BLOCK - 1);
    localparam logic [CNT_BITS-1:0] CNT_RESET = 8'h00;
    localparam logic [WORD_BITS-1:0] ERASED_WORD = 32'hffffffff;
    localparam logic [WORD_BITS-1:0] DENIED_WORD = 32'h00000000;

    typedef enum logic [1:0] {prot_open, prot_read_only, prot_exec_only, prot_spare} prot_type;
    typedef enum logic [1:0] {kind_fetch, kind_data, kind_debug, kind_spare} rd_kind_type;
endpackage : flash_pkg

// ### rtl/prot_check.sv
// Purpose: decode per-unit protection for one word address
// Assumes: prot_cfg holds one mode field per 2 KB unit, unit 0 lowest
// Notes: the spare mode code is treated as execute-only, the safer reading

`timescale 1ns/1ps

module prot_check
    import flash_pkg::*;
(
    // protection setting
    input wire logic [CFG_BITS-1:0] prot_cfg,
    // address under test
    input wire logic [ADDR_BITS-1:0] word_addr,
    // verdict
    output logic in_range,
    output logic wr_ok,
    output logic dread_ok,
    output prot_type unit_mode
);
    localparam int SLOTS = 1 << UNIT_BITS;

    logic [SLOTS-1:0] unit_wr_ok;
    logic [SLOTS-1:0] unit_dread_ok;
    logic [UNIT_BITS-1:0] unit_idx;
    logic [MODE_BITS-1:0] mode_tab [SLOTS];

    // two adjacent 1 KB blocks share one mode field
    assign unit_idx = word_addr[UNIT_POS +: UNIT_BITS];
    assign in_range = word_addr <= LAST_WORD;

    for (genvar i = 0; i < SLOTS; i++) begin : g_unit
        if (i < NUM_UNITS) begin : g_real
            assign mode_tab[i] = prot_cfg[i*MODE_BITS +: MODE_BITS];
        end else begin : g_none
            assign mode_tab[i] = 2'(prot_spare);
        end
        assign unit_wr_ok[i] = mode_tab[i] == 2'(prot_open);
        assign unit_dread_ok[i] = mode_tab[i] == 2'(prot_open) || mode_tab[i] == 2'(prot_read_only);
    end

    assign wr_ok = in_range && unit_wr_ok[unit_idx];
    assign dread_ok = in_range && unit_dread_ok[unit_idx];
    assign unit_mode = in_range ? prot_type'(mode_tab[unit_idx]) : prot_spare;
endmodule : prot_check

// ### testbench/flash_array_model.sv
// Purpose: behavioural flash array behind the controller
// Assumes: read data due the cycle after a read strobe
// Notes: outside that cycle the data lines toggle so stale words cannot pass

`timescale 1ns/1ps

module flash_array_model
    import flash_pkg::*;
(
    // clock
    input wire logic mclk,
    // read port
    input wire logic rd_en,
    input wire logic [ADDR_BITS-1:0] rd_addr,
    output logic [WORD_BITS-1:0] rd_data,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR_BITS-1:0] wr_addr,
    input wire logic [WORD_BITS-1:0] wr_data
);
    logic [WORD_BITS-1:0] mem [NUM_WORDS];

    initial rd_data = 32'h5a5a5a5a;

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        // hold time is one cycle, then the lines show garbage
        rd_data <= rd_en ? mem[rd_addr] : ~rd_data;
    end
endmodule : flash_array_model

// ### testbench/flash_block_erase_protect_tb_top.sv
// Purpose: self-checking bench for the block erase and protection controller
// Assumes: answer latencies are counted in edges from the edge that takes the request
// Notes: unit 1 covers blocks 2 and 3, so block 4 probes the unit edge

`timescale 1ns/1ps

module flash_block_erase_protect_tb_top;
    import flash_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [CFG_BITS-1:0] prot_cfg = '0;
    logic rd_req = 1'b0;
    rd_kind_type rd_kind = kind_fetch;
    logic [ADDR_BITS-1:0] rd_addr = '0;
    logic prog_req = 1'b0;
    logic [ADDR_BITS-1:0] prog_addr = '0;
    logic [WORD_BITS-1:0] prog_data = '0;
    logic erase_req = 1'b0;
    logic [BLK_BITS-1:0] erase_block = '0;
    logic rd_valid, rd_err, op_done, op_err, req_ready, arr_rd_en, arr_wr_en;
    logic [WORD_BITS-1:0] rd_data, arr_rd_data, arr_wr_data;
    logic [ADDR_BITS-1:0] arr_rd_addr, arr_wr_addr;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    always #4 mclk = ~mclk;

    flash_block_erase_protect dut (.mclk(mclk), .srst(srst), .prot_cfg(prot_cfg), .rd_req(rd_req),
        .rd_kind(rd_kind), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data), .erase_req(erase_req),
        .erase_block(erase_block), .op_done(op_done), .op_err(op_err), .req_ready(req_ready),
        .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data),
        .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data));

    flash_array_model array (.mclk(mclk), .rd_en(arr_rd_en), .rd_addr(arr_rd_addr), .rd_data(arr_rd_data),
        .wr_en(arr_wr_en), .wr_addr(arr_wr_addr), .wr_data(arr_wr_data));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // looks at the falling edge, so a one-cycle pulse is seen while it stands;
    // n is the rising edge, counted from the taking edge, that samples the answer
    task automatic wait_ans(output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!(rd_valid === 1'b1 || rd_err === 1'b1 || op_done === 1'b1 || op_err === 1'b1) && n < 300);
        check("ready after answer", {31'h0, req_ready}, 32'h1);
    endtask : wait_ans

    task automatic do_prog(input logic [14:0] a, input logic [31:0] d, input logic err);
        int n;
        @(posedge mclk);
        prog_req <= 1'b1;
        prog_addr <= a;
        prog_data <= d;
        @(posedge mclk);
        prog_req <= 1'b0;
        wait_ans(n);
        check("prog latency", 32'(n), err ? 32'h1 : 32'h2);
        check("prog error", {31'h0, op_err}, {31'h0, err});
    endtask : do_prog

    task automatic do_erase(input logic [6:0] b, input logic err);
        int n;
        @(posedge mclk);
        erase_req <= 1'b1;
        erase_block <= b;
        @(posedge mclk);
        erase_req <= 1'b0;
        wait_ans(n);
        check("erase latency", 32'(n), err ? 32'h1 : 32'h102);
        check("erase error", {31'h0, op_err}, {31'h0, err});
    endtask : do_erase

    task automatic do_read(input rd_kind_type k, input logic [14:0] a, input logic err, input logic [31:0] d);
        int n;
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_kind <= k;
        rd_addr <= a;
        @(posedge mclk);
        rd_req <= 1'b0;
        wait_ans(n);
        check("read latency", 32'(n), err ? 32'h1 : 32'h3);
        check("read error", {31'h0, rd_err}, {31'h0, err});
        check("read data", rd_data, err ? DENIED_WORD : d);
    endtask : do_read

    task automatic set_unit(input int u, input prot_type m);
        @(posedge mclk);
        prot_cfg[2*u +: 2] <= m;
    endtask : set_unit

    task automatic t_open_erase();
        do_prog(15'h02ff, 32'h12345678, 1'b0);
        do_prog(15'h0305, 32'ha5a5a5a5, 1'b0);
        do_prog(15'h0400, 32'h0f0f0f0f, 1'b0);
        do_read(kind_data, 15'h0305, 1'b0, 32'ha5a5a5a5);
        do_erase(7'h03, 1'b0);
        do_read(kind_data, 15'h0300, 1'b0, ERASED_WORD);
        do_read(kind_debug, 15'h0305, 1'b0, ERASED_WORD);
        do_read(kind_data, 15'h03ff, 1'b0, ERASED_WORD);
        do_read(kind_data, 15'h02ff, 1'b0, 32'h12345678);
        do_read(kind_data, 15'h0400, 1'b0, 32'h0f0f0f0f);
        $display("test open_erase done");
    endtask : t_open_erase

    task automatic t_read_only();
        do_prog(15'h0305, 32'h00c0ffee, 1'b0);
        set_unit(1, prot_read_only);
        do_prog(15'h02ff, 32'h0, 1'b1);
        do_erase(7'h02, 1'b1);
        do_erase(7'h03, 1'b1);
        do_read(kind_data, 15'h02ff, 1'b0, 32'h12345678);
        do_read(kind_debug, 15'h0305, 1'b0, 32'h00c0ffee);
        do_erase(7'h04, 1'b0);
        do_read(kind_data, 15'h0400, 1'b0, ERASED_WORD);
        $display("test read_only done");
    endtask : t_read_only

    task automatic t_exec_only();
        set_unit(1, prot_exec_only);
        do_prog(15'h0305, 32'h0, 1'b1);
        do_erase(7'h03, 1'b1);
        do_read(kind_fetch, 15'h02ff, 1'b0, 32'h12345678);
        do_read(kind_data, 15'h02ff, 1'b1, 32'h0);
        do_read(kind_debug, 15'h0305, 1'b1, 32'h0);
        do_read(kind_spare, 15'h02ff, 1'b1, 32'h0);
        set_unit(1, prot_spare);
        do_read(kind_data, 15'h0305, 1'b1, 32'h0);
        do_read(kind_fetch, 15'h0305, 1'b0, 32'h00c0ffee);
        set_unit(1, prot_open);
        do_read(kind_data, 15'h0305, 1'b0, 32'h00c0ffee);
        do_read(kind_data, 15'h6000, 1'b1, 32'h0);
        $display("test exec_only done");
    endtask : t_exec_only

    // ceiling sized for two full erases plus some thirty short requests
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        t_open_erase();
        t_read_only();
        t_exec_only();
        give_verdict();
    end
endmodule : flash_block_erase_protect_tb_top
